// >>> shared/mrf_pkg.sv
package mrf_pkg;
    localparam logic [4:0] OFF_CTRL  = 5'h00;
    localparam logic [4:0] OFF_STAT  = 5'h04;
    localparam logic [4:0] OFF_FADDR = 5'h08;
    localparam logic [4:0] OFF_SHIFT = 5'h0c;
    localparam logic [4:0] OFF_LEN   = 5'h10;
    localparam logic [4:0] OFF_IRQS  = 5'h14;
    localparam logic [4:0] OFF_IRQM  = 5'h18;
    localparam int CTRL_MODE  = 0;
    localparam int CTRL_OP    = 2;
    localparam int CTRL_START = 4;
    localparam int CTRL_HOLD  = 5;
    localparam int CTRL_CAP   = 6;
    localparam int CTRL_MAXR  = 8;
    localparam int FADDR_WR   = 16;
    localparam int FADDR_RD   = 17;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_FAIL   = 1;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [1:0]  IRQM_RST = 2'h0;
    localparam logic [1:0]  FB_ACC_INT = 2'h2;
    localparam logic [1:0]  FB_ACC_EXT = 2'h3;
    localparam int FA_W = 16;
    typedef enum logic [1:0] {
        MODE_NONE  = 2'b00,
        MODE_FUSE  = 2'b01,
        MODE_CHAIN = 2'b10,
        MODE_AUTO  = 2'b11
    } mrf_mode_t;
    typedef enum logic [1:0] {
        OP_LOADER = 2'b00,
        OP_PROG   = 2'b01,
        OP_VERIFY = 2'b10,
        OP_ROTATE = 2'b11
    } mrf_op_t;
    typedef struct packed {
        logic            wr;
        logic            rd;
        logic            commit;
        logic [FA_W-1:0] addr;
    } mrf_fb_req_t;
endpackage

// >>> hw/mrf_ctrl.sv
// Memory repair fuse controller: repair chain sequencer, fuse box access and bus slave.
//
// The register offsets and register access over Avalon-MM were decided locally.
module mrf_ctrl #(
    parameter int              NCH        = 2,
    parameter int              LW         = 16,
    parameter logic [LW-1:0]   MAX_LEN    = 16'd1024,
    parameter logic [LW-1:0]   FUSE_COUNT = 16'd1024,
    parameter bit              EXT_FUSE   = 1'b0
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic [4:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    output logic                     irq,
    output logic      [NCH-1:0]      rr_si,
    input  wire logic [NCH-1:0]      rr_so,
    output logic                     rr_shift,
    output logic                     rr_capture,
    output mrf_pkg::mrf_fb_req_t     fb_req,
    input  wire logic                fb_rdata,
    input  wire logic                fb_done,
    output logic                     done_o,
    output logic                     pass_o
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CLR  = 3'b001,
        S_MEAS = 3'b010,
        S_ROT  = 3'b011,
        S_FB   = 3'b100,
        S_FACC = 3'b101,
        S_CAP  = 3'b110,
        S_END  = 3'b111
    } mrf_state_t;

    mrf_state_t st_r, st_nxt;
    logic [15:0]           ctrl_r;
    logic [LW-1:0]         cnt_r, len_r, nprog_r;
    logic [mrf_pkg::FA_W-1:0] faddr_r;
    logic                  facc_wr_r, facc_rd_r;
    logic [1:0]            irqs_r, irqm_r;
    logic                  head_r, shp_r, so_bit_r, fbit_r;
    logic                  done_r, pass_r, ok_r, resp_r;
    mrf_pkg::mrf_op_t      op_r;
    logic [31:0]           rdata_r;

    wire                   req      = avs_read | avs_write;
    wire                   acc      = req & resp_r;
    wire                   wr_acc   = acc & avs_write;
    wire                   rd_acc   = acc & avs_read;
    wire [1:0]             mode     = ctrl_r[mrf_pkg::CTRL_MODE +: 2];
    wire [7:0]             maxr     = ctrl_r[mrf_pkg::CTRL_MAXR +: 8];
    wire                   hold     = ctrl_r[mrf_pkg::CTRL_HOLD];
    wire                   idle     = st_r == S_IDLE;
    wire                   wr_ctrl  = wr_acc & (avs_address == mrf_pkg::OFF_CTRL);
    wire                   wr_faddr = wr_acc & (avs_address == mrf_pkg::OFF_FADDR);
    wire                   wr_shift = wr_acc & (avs_address == mrf_pkg::OFF_SHIFT);
    wire                   wr_irqs  = wr_acc & (avs_address == mrf_pkg::OFF_IRQS);
    wire                   wr_irqm  = wr_acc & (avs_address == mrf_pkg::OFF_IRQM);
    wire [1:0]             w_mode   = avs_writedata[mrf_pkg::CTRL_MODE +: 2];
    // A start is honoured only while idle and only for the mode it names.
    wire start_auto = wr_ctrl & idle & avs_writedata[mrf_pkg::CTRL_START]
                      & (w_mode == mrf_pkg::MODE_AUTO);
    wire start_cap  = wr_ctrl & idle & avs_writedata[mrf_pkg::CTRL_CAP]
                      & (w_mode == mrf_pkg::MODE_CHAIN);
    wire start_facc = wr_faddr & idle & (mode == mrf_pkg::MODE_FUSE)
                      & (avs_writedata[mrf_pkg::FADDR_WR] ^ avs_writedata[mrf_pkg::FADDR_RD]);
    wire shift_ok   = wr_shift & idle & (mode == mrf_pkg::MODE_CHAIN);
    wire [1:0] acc_len = EXT_FUSE ? mrf_pkg::FB_ACC_EXT : mrf_pkg::FB_ACC_INT;

    // Chains are concatenated: chain k feeds chain k+1, last chain is the output end.
    wire [NCH:0] lnk;
    wire         tail = lnk[NCH];
    wire         rot  = (st_r == S_ROT) | (st_r == S_FB);
    wire         head = rot ? tail : head_r;
    assign lnk   = {rr_so, head};
    assign rr_si = lnk[NCH-1:0];

    wire under   = (maxr == 8'h00) | (nprog_r < LW'(maxr));
    wire need_fb = (op_r == mrf_pkg::OP_VERIFY)
                   | ((op_r == mrf_pkg::OP_PROG) & tail & under);
    wire rot_end = cnt_r == len_r;
    wire oob     = cnt_r >= FUSE_COUNT;
    wire meas_hit = (cnt_r != '0) & tail;
    wire meas_to  = cnt_r == MAX_LEN;
    wire clr_end  = cnt_r == MAX_LEN - 1'b1;
    wire fb_step  = (st_r == S_FB) & fb_done;
    wire fb_miss  = fb_step & (op_r == mrf_pkg::OP_VERIFY) & (fb_rdata != tail);
    wire facc_end = (st_r == S_FACC) & (cnt_r[1:0] == acc_len - 2'd1);

    // Rotation shifts only when no fuse action is pending, so the chain returns intact.
    assign rr_shift = shp_r | (st_r == S_CLR) | (st_r == S_MEAS)
                      | ((st_r == S_ROT) & ~rot_end & ~need_fb) | fb_step;
    assign rr_capture = st_r == S_CAP;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (start_auto) begin
                    st_nxt = (w_mode == mrf_pkg::MODE_AUTO)
                             && (avs_writedata[mrf_pkg::CTRL_OP +: 2] == mrf_pkg::OP_LOADER)
                             ? S_CLR : S_ROT;
                end else if (start_cap) begin
                    st_nxt = S_CAP;
                end else if (start_facc) begin
                    st_nxt = S_FACC;
                end
            end
            S_CLR:  st_nxt = clr_end ? S_MEAS : S_CLR;
            S_MEAS: st_nxt = (meas_hit | meas_to) ? S_END : S_MEAS;
            S_ROT: begin
                if (rot_end) begin
                    st_nxt = S_END;
                end else if (need_fb) begin
                    st_nxt = oob ? S_END : S_FB;
                end
            end
            S_FB:   st_nxt = fb_done ? S_ROT : S_FB;
            S_FACC: st_nxt = facc_end ? S_IDLE : S_FACC;
            S_CAP:  st_nxt = S_ROT;
            S_END:  st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always_comb begin
        fb_req = '0;
        if (st_r == S_FACC) begin
            fb_req.wr   = facc_wr_r;
            fb_req.rd   = facc_rd_r;
            fb_req.addr = faddr_r;
        end else if (st_r == S_FB) begin
            fb_req.wr   = op_r == mrf_pkg::OP_PROG;
            fb_req.rd   = op_r == mrf_pkg::OP_VERIFY;
            fb_req.addr = mrf_pkg::FA_W'(cnt_r);
        end
        // Without the hold the buffered fuse image is committed when programming ends.
        fb_req.commit = (st_r == S_END) & (op_r == mrf_pkg::OP_PROG) & ~hold;
    end

    wire meas_to_end = (st_r == S_END) & (op_r == mrf_pkg::OP_LOADER) & (len_r == '0);
    wire end_ok = ok_r & ~((st_r == S_ROT) & need_fb & oob) & ~meas_to_end;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        // The bit index must survive a fuse action, or later fuses land on wrong addresses.
        end else if (st_nxt != st_r && st_nxt != S_ROT && st_nxt != S_MEAS
                     && st_nxt != S_FB) begin
            cnt_r <= '0;
        end else if (st_r == S_CLR && clr_end) begin
            cnt_r <= '0;
        end else if (st_r == S_CAP || st_r == S_IDLE) begin
            cnt_r <= '0;
        end else if (rr_shift | (st_r == S_FACC)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ok_r    <= 1'b0;
            nprog_r <= '0;
            op_r    <= mrf_pkg::OP_LOADER;
        end else if (start_auto | start_cap) begin
            ok_r    <= 1'b1;
            nprog_r <= '0;
            op_r    <= start_cap ? mrf_pkg::OP_ROTATE
                       : mrf_pkg::mrf_op_t'(avs_writedata[mrf_pkg::CTRL_OP +: 2]);
        end else begin
            if (fb_miss | ((st_r == S_ROT) & need_fb & oob)) begin
                ok_r <= 1'b0;
            end
            if (fb_step & (op_r == mrf_pkg::OP_PROG)) begin
                nprog_r <= nprog_r + 1'b1;
            end
        end
    end

    // The length is kept until the next loader reset, for later operations.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            len_r <= '0;
        end else if (st_r == S_CLR) begin
            len_r <= '0;
        end else if (st_r == S_MEAS && meas_hit) begin
            len_r <= cnt_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
            pass_r <= 1'b0;
        end else if (start_auto | start_cap) begin
            done_r <= 1'b0;
            pass_r <= 1'b0;
        end else if (st_r == S_END) begin
            done_r <= 1'b1;
            pass_r <= end_ok;
        end
    end
    assign done_o = done_r;
    assign pass_o = pass_r;

    // Chain access: the bit falling off the output end is kept for the tester.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            head_r   <= 1'b0;
            shp_r    <= 1'b0;
            so_bit_r <= 1'b0;
        end else begin
            shp_r <= shift_ok;
            if (shift_ok) begin
                head_r   <= avs_writedata[0];
                so_bit_r <= tail;
            end else if (st_nxt == S_MEAS && st_r == S_CLR) begin
                head_r <= 1'b1;
            end else if (shp_r | (st_r == S_MEAS) | start_auto) begin
                head_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            faddr_r   <= '0;
            facc_wr_r <= 1'b0;
            facc_rd_r <= 1'b0;
            fbit_r    <= 1'b0;
        end else begin
            if (start_facc) begin
                faddr_r   <= avs_writedata[mrf_pkg::FA_W-1:0];
                facc_wr_r <= avs_writedata[mrf_pkg::FADDR_WR];
                facc_rd_r <= avs_writedata[mrf_pkg::FADDR_RD];
            end
            // The fuse box done line is not trusted here; a fixed window is used.
            if (facc_end & facc_rd_r) begin
                fbit_r <= fb_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= mrf_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= avs_writedata[15:0] & 16'hffaf;
        end
    end

    // Event set wins over a write-one clear in the same cycle.
    wire [1:0] irq_set = {(st_r == S_END) & ~end_ok, st_r == S_END};
    wire [1:0] irq_clr = wr_irqs ? avs_writedata[1:0] : 2'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqs_r <= 2'h0;
            irqm_r <= mrf_pkg::IRQM_RST;
        end else begin
            irqs_r <= (irqs_r & ~irq_clr) | irq_set;
            if (wr_irqm) begin
                irqm_r <= avs_writedata[1:0];
            end
        end
    end
    assign irq = |(irqs_r & irqm_r);

    // Every access waits one cycle so read data can come from a flop.
    assign avs_waitrequest = req & ~resp_r;
    wire [31:0] rd_mux =
        (avs_address == mrf_pkg::OFF_CTRL)  ? {16'h0000, ctrl_r} :
        (avs_address == mrf_pkg::OFF_STAT)  ? {27'h0, so_bit_r, fbit_r, pass_r, done_r, ~idle} :
        (avs_address == mrf_pkg::OFF_FADDR) ? {14'h0, facc_rd_r, facc_wr_r, faddr_r} :
        (avs_address == mrf_pkg::OFF_SHIFT) ? {31'h0, so_bit_r} :
        (avs_address == mrf_pkg::OFF_LEN)   ? 32'(len_r) :
        (avs_address == mrf_pkg::OFF_IRQS)  ? {30'h0, irqs_r} :
        (avs_address == mrf_pkg::OFF_IRQM)  ? {30'h0, irqm_r} : 32'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resp_r  <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            resp_r <= req & ~resp_r;
            if (avs_read & ~resp_r) begin
                rdata_r <= rd_mux;
            end
        end
    end
    assign avs_readdata = rdata_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    AST_CAP_ROT: assert property (rr_capture |=> st_r == S_ROT && op_r == mrf_pkg::OP_ROTATE)
        else $error("capture not followed by rotation");
    AST_DONE_PASS: assert property (st_r == S_END && end_ok |=> done_o && pass_o)
        else $error("success without pass and done");
    AST_FACC_WIN: assert property ($rose(st_r == S_FACC) |-> (fb_req.wr || fb_req.rd) [*2])
        else $error("fuse port access window too short");
    AST_ONE_FUSE: assert property (fb_req.wr || fb_req.rd |-> !(fb_req.wr && fb_req.rd)
        && (!$past(fb_req.wr || fb_req.rd) || $stable(fb_req.addr)))
        else $error("fuse access not single bit");
    AST_COMMIT: assert property (fb_req.commit |-> !hold && $past(st_r) == S_ROT)
        else $error("commit while held");
    AST_MAXR: assert property ($rose(st_r == S_FB) && op_r == mrf_pkg::OP_PROG
        |-> maxr == 8'h00 || nprog_r < LW'(maxr))
        else $error("repair count exceeded");
    AST_ROT_END: assert property (st_r == S_ROT && rot_end |=> st_r == S_END)
        else $error("rotation overran chain length");
    AST_LEN_KEEP: assert property (st_r == S_MEAS && meas_hit |=> len_r == $past(cnt_r))
        else $error("chain length not kept");
    AST_ROT_LOOP: assert property (rot && rr_shift |-> rr_si[0] == tail)
        else $error("rotation not closed");
    COV_LOADER: cover property (st_r == S_MEAS && meas_hit);
    COV_PROG: cover property (fb_req.commit);
    COV_VERIFY_OK: cover property (st_r == S_END && op_r == mrf_pkg::OP_VERIFY && end_ok);
endmodule

// >>> sim/mrf_fuse_model.sv
// Behavioural repair chains and fuse box that face the repair controller.
module mrf_fuse_model #(
    parameter logic [4:0] CAP0 = 5'h0b,
    parameter logic [6:0] CAP1 = 7'h25
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [1:0]           rr_si,
    output logic      [1:0]           rr_so,
    input  wire logic                 rr_shift,
    input  wire logic                 rr_capture,
    input  wire mrf_pkg::mrf_fb_req_t fb_req,
    output logic                      fb_rdata,
    output logic                      fb_done,
    input  wire logic [3:0]           fb_wait,
    output logic      [63:0]          fuses,
    output logic      [7:0]           n_commit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] c0_r;
    logic [6:0] c1_r;
    logic [3:0] cnt_r;
    logic       last_r;
    wire        act = fb_req.wr | fb_req.rd;
    wire        hit = fb_req.addr < 16'h0040;
    // Chain 1 ends at the output, so its low bit is chain index 0.
    assign rr_so = {c1_r[0], c0_r[0]};
    // An idle read line toggles so that a stale value can never pass for data.
    assign fb_rdata = (fb_req.rd && hit) ? fuses[fb_req.addr[5:0]] : ~last_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            c0_r <= 5'h00;
            c1_r <= 7'h00;
            cnt_r <= 4'h0;
            last_r <= 1'b0;
            fb_done <= 1'b0;
            fuses <= 64'h0;
            n_commit <= 8'h00;
        end else begin
            if (rr_capture) begin
                c0_r <= CAP0;
                c1_r <= CAP1;
            end else if (rr_shift) begin
                c0_r <= {rr_si[0], c0_r[4:1]};
                c1_r <= {rr_si[1], c1_r[6:1]};
            end
            if (fb_req.wr && hit) begin
                fuses[fb_req.addr[5:0]] <= 1'b1;
            end
            if (fb_req.commit) begin
                n_commit <= n_commit + 8'h01;
            end
            last_r <= fb_rdata;
            if (!act || fb_done) begin
                cnt_r <= 4'h0;
                fb_done <= 1'b0;
            end else if (cnt_r == fb_wait) begin
                fb_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// >>> sim/memory_repair_fuse_controller_tb.sv
// Self-checking bench for the memory repair fuse controller.
module memory_repair_fuse_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic [4:0]           avs_address = 5'h00;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [31:0]          avs_writedata = 32'h0;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest, irq, rr_shift, rr_capture;
    logic                 fb_rdata, fb_done, done_o, pass_o;
    logic [1:0]           rr_si, rr_so;
    mrf_pkg::mrf_fb_req_t fb_req;
    logic [3:0]           fb_wait = 4'h0;
    logic [63:0]          fuses;
    logic [7:0]           n_commit;
    logic [31:0]          rd;
    int                   n_fail = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    always #2 ref_clk = ~ref_clk;
    mrf_ctrl #(.MAX_LEN(16'd32), .FUSE_COUNT(16'd64)) dut (.ref_clk, .rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .rr_si,
        .rr_so, .rr_shift, .rr_capture, .fb_req, .fb_rdata, .fb_done, .done_o, .pass_o);
    mrf_fuse_model model (.ref_clk, .rst, .rr_si, .rr_so, .rr_shift, .rr_capture, .fb_req,
        .fb_rdata, .fb_done, .fb_wait, .fuses, .n_commit);
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The request is held until the rising edge at which waitrequest is sampled low.
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk_irq(input logic exp);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    task automatic t_op(input logic [31:0] ctrl, input logic exp_pass, input string name);
        int n;
        n = 0;
        bus(mrf_pkg::OFF_CTRL, 1'b1, ctrl);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        while (done_o !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        chk({name, " done_o"}, 32'h1, {31'h0, done_o});
        chk({name, " pass_o"}, {31'h0, exp_pass}, {31'h0, pass_o});
        $display("test %s finished", name);
    endtask
    task automatic t_reset();
        bus(mrf_pkg::OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", {16'h0, mrf_pkg::CTRL_RST}, rd);
        bus(mrf_pkg::OFF_IRQM, 1'b0, 32'h0);
        chk("mask reset", {30'h0, mrf_pkg::IRQM_RST}, rd);
        bus(5'h1c, 1'b1, 32'hffff_ffff);
        bus(5'h1c, 1'b0, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset finished");
    endtask
    task automatic t_chain(input logic [11:0] pat, input logic ck, input logic [11:0] exp);
        bus(mrf_pkg::OFF_CTRL, 1'b1, 32'h2);
        for (int j = 0; j < 12; j++) begin
            bus(mrf_pkg::OFF_SHIFT, 1'b1, {31'h0, pat[j]});
            bus(mrf_pkg::OFF_STAT, 1'b0, 32'h0);
            if (ck) begin
                chk("bit shifted out", {31'h0, exp[j]}, {31'h0, rd[4]});
            end
        end
        $display("test chain access finished");
    endtask
    task automatic t_program(input logic [31:0] ctrl, input int nf, input logic [7:0] ncm);
        logic [7:0] c0;
        c0 = n_commit;
        t_op(ctrl, 1'b1, "fuse program");
        chk("fuses set", nf, $countones(fuses));
        chk("fuse 0", 32'h1, {31'h0, fuses[0]});
        chk("commits", {24'h0, ncm}, {24'h0, n_commit - c0});
    endtask
    task automatic t_fuse_port();
        bus(mrf_pkg::OFF_CTRL, 1'b1, 32'h1);
        bus(mrf_pkg::OFF_FADDR, 1'b1, 32'h0001_0007);
        repeat (3) @(posedge ref_clk);
        chk("fuse 7", 32'h1, {31'h0, fuses[7]});
        for (int a = 0; a < 64; a++) begin
            bus(mrf_pkg::OFF_FADDR, 1'b1, 32'h0002_0000 | a);
            repeat (3) @(posedge ref_clk);
            bus(mrf_pkg::OFF_STAT, 1'b0, 32'h0);
            chk("fuse read bit", {31'h0, a == 0 || a == 4 || a == 7}, {31'h0, rd[3]});
        end
        $display("test fuse port finished");
    endtask
    task automatic t_irq();
        bus(mrf_pkg::OFF_IRQS, 1'b0, 32'h0);
        chk("irq status", 32'h3, rd);
        chk_irq(1'b0);
        bus(mrf_pkg::OFF_IRQM, 1'b1, 32'h2);
        chk_irq(1'b1);
        bus(mrf_pkg::OFF_IRQS, 1'b1, 32'h2);
        chk_irq(1'b0);
        bus(mrf_pkg::OFF_IRQM, 1'b1, 32'h1);
        chk_irq(1'b1);
        bus(mrf_pkg::OFF_IRQS, 1'b1, 32'h1);
        chk_irq(1'b0);
        bus(mrf_pkg::OFF_IRQS, 1'b0, 32'h0);
        chk("irq cleared", 32'h0, rd);
        $display("test interrupt finished");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_op(32'h13, 1'b1, "loader reset");
        bus(mrf_pkg::OFF_LEN, 1'b0, 32'h0);
        chk("chain length", 32'd12, rd);
        t_chain(12'h011, 1'b1, 12'h000);
        t_chain(12'h011, 1'b1, 12'h011);
        fb_wait <= 4'h3;
        t_program(32'h137, 1, 8'h00);
        fb_wait <= 4'h0;
        t_chain(12'h011, 1'b1, 12'h011);
        t_program(32'h17, 2, 8'h01);
        t_op(32'h1b, 1'b1, "verify match");
        t_fuse_port();
        t_op(32'h1b, 1'b0, "verify mismatch");
        t_irq();
        t_op(32'h42, 1'b1, "capture");
        t_chain(12'h000, 1'b1, 12'h5a5);
        complete_run();
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end
endmodule
